// *** rte_regs.svh ***
// register map, field positions and reset values of the rf encoder block
// assumes an 8-bit special function register port with byte addresses
`ifndef RTE_REGS_SVH
`define RTE_REGS_SVH
`define RTE_ADDR_DATA 8'h8E
`define RTE_ADDR_LOOP 8'hD7
`define RTE_ADDR_LOCK 8'hDF
`define RTE_ADDR_STAT 8'hE6
`define RTE_ADDR_ENC 8'hE7
`define RTE_ADDR_TXC 8'hEE
`define RTE_RST_LOOP 8'h82
`define RTE_RST_LOCK_CFG 5'h08
`define RTE_RST_ENC 8'hE0
`define RTE_RST_TXC 2'h0
`define RTE_LEN_MSB 7
`define RTE_LEN_LSB 5
`define RTE_MASK_BIT 4
`define RTE_IDLE_BIT 3
`define RTE_MODE_MSB 2
`define RTE_FAIL_BIT 5
`define RTE_LDEN_BIT 4
`define RTE_LIM_MSB 3
`define RTE_SYN_BIT 1
`define RTE_PA_BIT 0
`define RTE_MODE_MAN 3'h0
`define RTE_MODE_IMAN 3'h1
`define RTE_MODE_DMAN 3'h2
`define RTE_MODE_BP0 3'h3
`define RTE_MODE_BP1 3'h4
`define RTE_MODE_CHIP 3'h5
`endif

// *** rte_pkg.sv ***
// types shared by the rf encoder files
// assumes rte_regs.svh supplies the numeric constants
package rte_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rte_bus_s;
  typedef enum logic [2:0] {
    RTE_IDLE = 3'b001,
    RTE_SEND = 3'b010,
    RTE_OFF = 3'b100
  } rte_state_e;
endpackage : rte_pkg

// *** rte_lock_detect.sv ***
// synthesizer lock detector: counts phase violations up to a limit
// assumes violation pulses are synchronous one-cycle pulses
`timescale 1ns/10ps
`include "rte_regs.svh"
module rte_lock_detect (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic lock_check_enable,
  input wire logic [3:0] violation_limit,
  input wire logic violation_pulse,
  output logic limit_hit
);
  import rte_pkg::*;
  logic [4:0] count_reg;
  logic [4:0] count_next;
  wire [4:0] limit_plus_one = {1'b0, violation_limit} + 5'h01;
  // a violation that reaches limit plus one fires once
  assign count_next = !lock_check_enable ? 5'h00 :
                      (violation_pulse && count_reg != limit_plus_one) ? count_reg + 5'h01 :
                      count_reg;
  assign limit_hit = lock_check_enable && violation_pulse &&
                     (count_reg + 5'h01 == limit_plus_one);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= 5'h00;
    end else begin
      count_reg <= count_next;
    end
  end
  a_count_cleared: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !lock_check_enable |=> count_reg == 5'h00) else $error("counter not cleared");
endmodule : rte_lock_detect

// *** rte_encoder.sv ***
// rf transmit bit encoder with control, status and lock detector registers
// assumes a single-cycle sfr port and a bit-rate tick from an external timer
`timescale 1ns/10ps
`include "rte_regs.svh"
module rte_encoder (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire rte_pkg::rte_bus_s sfr,
  input wire logic bit_tick,
  input wire logic violation_pulse,
  output logic [7:0] sfr_rdata,
  output logic encoder_out,
  output logic synth_enable,
  output logic amplifier_enable,
  output logic pa_on,
  output logic encoder_irq
);
  import rte_pkg::*;
  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0] enc_reg;
  logic [7:0] loop_reg;
  logic [4:0] lock_cfg_reg;
  logic fail_reg;
  logic [1:0] txc_reg;
  logic [7:0] buf_reg;
  logic full_reg;
  logic [7:0] shift_reg;
  logic [3:0] left_reg;
  logic empty_reg;
  logic [2:0] phase_reg;
  logic diff_reg;
  logic cur_bit_reg;
  rte_state_e state_reg;
  rte_state_e state_next;
  function automatic logic [3:0] bits_of(input logic [2:0] len);
    bits_of = (len == 3'h0) ? 4'h1 : {1'b0, len} + 4'h1;
  endfunction : bits_of
  wire wr_data = sfr.wr && sfr.addr == `RTE_ADDR_DATA;
  wire wr_enc = sfr.wr && sfr.addr == `RTE_ADDR_ENC;
  wire wr_lock = sfr.wr && sfr.addr == `RTE_ADDR_LOCK;
  wire wr_loop = sfr.wr && sfr.addr == `RTE_ADDR_LOOP;
  wire wr_txc = sfr.wr && sfr.addr == `RTE_ADDR_TXC;
  wire rd_lock = sfr.rd && sfr.addr == `RTE_ADDR_LOCK;
  wire [2:0] mode = enc_reg[`RTE_MODE_MSB:0];
  wire chip_mode = mode == `RTE_MODE_CHIP;
  // bit_tick is eight per bit; half a bit is four ticks, chips take half a bit each
  wire half_done = bit_tick && phase_reg[1:0] == 2'h3;
  wire bit_done = chip_mode ? half_done : (half_done && phase_reg[2]);
  wire last_bit = left_reg == 4'h1;
  wire load = full_reg && (state_reg != RTE_SEND || (bit_done && last_bit));
  wire limit_hit;
  // ************************************************************
  // lock detector
  // ************************************************************
  rte_lock_detect u_lock (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .lock_check_enable(lock_cfg_reg[`RTE_LDEN_BIT]),
    .violation_limit(lock_cfg_reg[`RTE_LIM_MSB:0]),
    .violation_pulse(violation_pulse),
    .limit_hit(limit_hit)
  );
  // set wins over the read clear
  wire fail_next = limit_hit ? 1'b1 : (rd_lock ? 1'b0 : fail_reg);
  // ************************************************************
  // sequencing
  // ************************************************************
  always_comb begin
    case (state_reg)
      RTE_IDLE: state_next = load ? RTE_SEND : RTE_IDLE;
      RTE_SEND: begin
        if (bit_done && last_bit && !load) begin
          state_next = (txc_reg == 2'h3) ? RTE_IDLE : RTE_OFF;
        end else begin
          state_next = RTE_SEND;
        end
      end
      RTE_OFF: state_next = load ? RTE_SEND : (txc_reg == 2'h3 ? RTE_IDLE : RTE_OFF);
      default: state_next = RTE_IDLE;
    endcase
  end
  wire sym_bit = state_reg == RTE_SEND ? cur_bit_reg : enc_reg[`RTE_IDLE_BIT];
  wire second_half = phase_reg[2];
  logic line_next;
  always_comb begin
    case (mode)
      `RTE_MODE_MAN: line_next = sym_bit ^ second_half;
      `RTE_MODE_IMAN: line_next = ~(sym_bit ^ second_half);
      `RTE_MODE_DMAN: line_next = diff_reg ^ second_half;
      `RTE_MODE_BP0: line_next = second_half ? diff_reg ^ ~sym_bit : diff_reg;
      `RTE_MODE_BP1: line_next = second_half ? diff_reg ^ sym_bit : diff_reg;
      `RTE_MODE_CHIP: line_next = sym_bit;
      default: line_next = sym_bit;
    endcase
  end
  // differential level advances at each bit boundary
  wire diff_adv = mode == `RTE_MODE_DMAN ? diff_reg ^ ~sym_bit : diff_reg ^ 1'b1;
  wire tx_active = state_reg == RTE_SEND || (state_reg == RTE_IDLE && txc_reg == 2'h3);
  logic [7:0] rd_mux;
  always_comb begin
    case (sfr.addr)
      `RTE_ADDR_ENC: rd_mux = enc_reg;
      `RTE_ADDR_STAT: rd_mux = {6'h00, empty_reg, full_reg};
      `RTE_ADDR_LOCK: rd_mux = {2'h0, fail_reg, 5'h00};
      `RTE_ADDR_TXC: rd_mux = {6'h00, txc_reg};
      default: rd_mux = 8'h00;
    endcase
  end
  // ************************************************************
  // state registers
  // ************************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      enc_reg <= `RTE_RST_ENC;
      loop_reg <= `RTE_RST_LOOP;
      lock_cfg_reg <= `RTE_RST_LOCK_CFG;
      fail_reg <= 1'b0;
      txc_reg <= `RTE_RST_TXC;
      state_reg <= RTE_IDLE;
    end else begin
      if (wr_enc) enc_reg <= sfr.wdata;
      if (wr_loop) loop_reg <= sfr.wdata;
      if (wr_lock) lock_cfg_reg <= sfr.wdata[`RTE_LDEN_BIT:0];
      if (wr_txc) txc_reg <= sfr.wdata[`RTE_SYN_BIT:0];
      fail_reg <= fail_next;
      state_reg <= state_next;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_reg <= 8'h00;
      full_reg <= 1'b0;
      shift_reg <= 8'h00;
      left_reg <= 4'h0;
      empty_reg <= 1'b1;
    end else begin
      if (wr_data) buf_reg <= sfr.wdata;
      full_reg <= wr_data | (full_reg & ~load);
      if (load) begin
        shift_reg <= buf_reg;
        left_reg <= bits_of(enc_reg[`RTE_LEN_MSB:`RTE_LEN_LSB]);
        empty_reg <= 1'b0;
      end else if (bit_done && state_reg == RTE_SEND) begin
        shift_reg <= {shift_reg[6:0], 1'b0};
        left_reg <= left_reg - 4'h1;
        if (last_bit) empty_reg <= 1'b1;
      end
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= 3'h0;
      diff_reg <= 1'b0;
      cur_bit_reg <= 1'b0;
    end else begin
      if (load) phase_reg <= 3'h0;
      else if (bit_tick) phase_reg <= phase_reg + 3'h1;
      if (bit_done) diff_reg <= diff_adv;
      cur_bit_reg <= load ? buf_reg[7] : (bit_done ? shift_reg[6] : cur_bit_reg);
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00;
      encoder_out <= 1'b0;
      synth_enable <= 1'b0;
      amplifier_enable <= 1'b0;
      pa_on <= 1'b0;
      encoder_irq <= 1'b0;
    end else begin
      sfr_rdata <= rd_mux;
      encoder_out <= tx_active ? line_next : 1'b0;
      synth_enable <= txc_reg[`RTE_SYN_BIT];
      amplifier_enable <= txc_reg[`RTE_PA_BIT];
      pa_on <= state_next == RTE_SEND || (state_next == RTE_IDLE && txc_reg == 2'h3);
      encoder_irq <= load && !enc_reg[`RTE_MASK_BIT];
    end
  end
  // ************************************************************
  // checks
  // ************************************************************
  a_write_sets_full: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_data |=> full_reg) else $error("buffer flag not set");
  a_irq_masked: assert property (@(posedge sys_clk) disable iff (!rst_n)
    enc_reg[`RTE_MASK_BIT] && !wr_enc |=> !encoder_irq) else $error("masked irq");
  a_fail_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
    limit_hit |=> fail_reg) else $error("no-lock flag missed");
  a_fail_read_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_lock && !limit_hit |=> !fail_reg) else $error("read did not clear");
  a_load_count: assert property (@(posedge sys_clk) disable iff (!rst_n)
    load |=> left_reg == bits_of($past(enc_reg[`RTE_LEN_MSB:`RTE_LEN_LSB])))
    else $error("bit count wrong");
  a_empty_on_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
    load |=> !empty_reg) else $error("empty flag stuck");
  a_pa_off_end: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg == RTE_OFF |-> !pa_on || load) else $error("amplifier left on");
  a_idle_symbol: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg == RTE_IDLE && txc_reg == 2'h3 && chip_mode |=>
    encoder_out == $past(enc_reg[`RTE_IDLE_BIT]))
    else $error("idle symbol wrong");
endmodule : rte_encoder

// *** rte_synth_model.sv ***
// synthesizer and bit-rate timer stand-in at the far side of the encoder
// assumes slip_req is a one-cycle pulse from the bench
`timescale 1ns/10ps
module rte_synth_model #(
  parameter int TDIV = 2
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic synth_enable,
  input wire logic slip_req,
  output logic bit_tick,
  output logic violation_pulse
);
  logic [7:0] div_reg;
  // phase slips only exist while the synthesizer runs
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 8'h00;
      bit_tick <= 1'b0;
      violation_pulse <= 1'b0;
    end else begin
      div_reg <= (div_reg == 8'(TDIV - 1)) ? 8'h00 : div_reg + 8'h01;
      bit_tick <= (div_reg == 8'(TDIV - 1));
      violation_pulse <= slip_req & synth_enable;
    end
  end
endmodule : rte_synth_model

// *** tb.sv ***
// self-checking bench: registers, transfers and lock detector of rte_encoder
// assumes rte_synth_model supplies bit ticks and phase slips
`timescale 1ns/10ps
`include "rte_regs.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb;
  import rte_pkg::*;
  localparam int TDIV = 2;
  logic sys_clk, rst_n, bit_tick, violation_pulse, slip_req;
  logic encoder_out, synth_enable, amplifier_enable, pa_on, encoder_irq;
  logic [7:0] sfr_rdata, rd_val;
  logic [3:0] lim;
  logic cnt_clr;
  logic [7:0] ra [6] = '{8'hE7, 8'hDF, 8'hD7, 8'hE6, 8'hEE, 8'h55};
  logic [7:0] rv [6] = '{8'hE0, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
  rte_bus_s sfr;
  int err_total, tests_run, pa_cyc, irq_cnt, ex;
  rte_encoder DUT (.sys_clk(sys_clk), .rst_n(rst_n), .sfr(sfr), .bit_tick(bit_tick),
    .violation_pulse(violation_pulse), .sfr_rdata(sfr_rdata), .encoder_out(encoder_out),
    .synth_enable(synth_enable), .amplifier_enable(amplifier_enable), .pa_on(pa_on),
    .encoder_irq(encoder_irq));
  rte_synth_model #(.TDIV(TDIV)) SYN (.sys_clk(sys_clk), .rst_n(rst_n),
    .synth_enable(synth_enable), .slip_req(slip_req), .bit_tick(bit_tick),
    .violation_pulse(violation_pulse));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // amplifier time is the only view of bit count and rate at the pins
  // counters are cleared here only, so each has a single driving process
  always @(posedge sys_clk) begin
    pa_cyc <= cnt_clr ? 0 : pa_cyc + int'(pa_on);
    irq_cnt <= cnt_clr ? 0 : irq_cnt + int'(encoder_irq);
  end
  // ****
  // tasks
  // ****
  task automatic test_done;
    if (err_total == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr.wr = 1'b1;
    sfr.addr = a;
    sfr.wdata = d;
    cyc(1);
    sfr.wr = 1'b0;
    // one idle edge, so a following call never re-raises the strobe in the same step
    cyc(1);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    sfr.rd = 1'b1;
    sfr.addr = a;
    cyc(1);
    sfr.rd = 1'b0;
    rd_val = sfr_rdata;
    cyc(1);
  endtask : rd
  task automatic slip(input int n);
    repeat (n) begin
      slip_req = 1'b1;
      cyc(1);
      slip_req = 1'b0;
      cyc(1);
    end
    cyc(2);
  endtask : slip
  task automatic poll(input logic [7:0] v);
    int k = 0;
    rd(`RTE_ADDR_STAT);
    while (rd_val !== v && k < 600) begin
      rd(`RTE_ADDR_STAT);
      k++;
    end
  endtask : poll
  function automatic int exp_cyc(input logic [2:0] len, input logic [2:0] mode);
    return 2 * ((len == 3'h0) ? 1 : int'(len) + 1) * ((mode == `RTE_MODE_CHIP) ? 4 : 8) * TDIV;
  endfunction : exp_cyc
  // two bytes back to back, so the second waits in the buffer
  task automatic send(input int i);
    logic [2:0] len, mode;
    logic idle, mask;
    logic [1:0] txc;
    logic [7:0] d;
    len = (i < 8) ? 3'(i) : 3'($urandom);
    mode = 3'(i % 6);
    idle = 1'($urandom);
    mask = 1'($urandom);
    d = 8'($urandom);
    txc = (i % 4 > 1) ? 2'h3 : 2'h0;
    ex = exp_cyc(len, mode);
    wr(`RTE_ADDR_TXC, {6'h00, txc});
    `CHK({synth_enable, amplifier_enable}, txc)
    wr(`RTE_ADDR_ENC, {len, mask, idle, mode});
    cnt_clr = 1'b1;
    wr(`RTE_ADDR_DATA, d);
    cnt_clr = 1'b0;
    poll(8'h00);
    wr(`RTE_ADDR_DATA, ~d);
    rd(`RTE_ADDR_STAT);
    `CHK(rd_val, 8'h01)
    poll(8'h02);
    `CHK(rd_val, 8'h02)
    cyc(2);
    `CHK(irq_cnt, mask ? 0 : 2)
    if (txc == 2'h0) begin
      `CHK(pa_cyc >= ex - 10 && pa_cyc <= ex + 10, 1'b1)
      `CHK(pa_on, 1'b0)
    end else begin
      `CHK(pa_on, 1'b1)
      // coded modes toggle during idle (biphase only at bit edges for one idle level); raw chips show it as a level
      wr(`RTE_ADDR_ENC, {len, mask, idle, `RTE_MODE_CHIP});
      `CHK(encoder_out, idle)
    end
  endtask : send
  // ****
  // main sequence
  // ****
  initial begin
    sfr = '0;
    slip_req = 1'b0;
    rst_n = 1'b0;
    err_total = 0;
    tests_run = 0;
    cnt_clr = 1'b0;
    void'($urandom(95));
    cyc(8);
    rst_n = 1'b1;
    foreach (ra[k]) begin
      rd(ra[k]);
      `CHK(rd_val, rv[k])
      if (k > 1) wr(ra[k], 8'hFC);
      if (k > 1) rd(ra[k]);
      if (k > 1) `CHK(rd_val, (k == 4) ? 8'h00 : rv[k])
    end
    ex = $urandom;
    wr(8'hE7, 8'(ex));
    rd(8'hE7);
    `CHK(rd_val, 8'(ex))
    wr(8'hEE, 8'h02);
    for (int j = 0; j < 2; j++) begin
      lim = (j == 0) ? 4'h0 : 4'($urandom_range(14, 1));
      // a count left from the last round would shift the limit
      wr(8'hDF, {4'h0, lim});
      wr(8'hDF, {4'h1, lim});
      slip(int'(lim));
      rd(8'hDF);
      `CHK(rd_val[5], 1'b0)
      slip(1);
      rd(8'hDF);
      `CHK(rd_val, 8'h20)
      rd(8'hDF);
      `CHK(rd_val[5], 1'b0)
      wr(8'hDF, {4'h0, lim});
      wr(8'hDF, {4'h1, lim});
      slip(int'(lim));
      wr(8'hDF, {4'h0, lim});
      slip(1);
      wr(8'hDF, {4'h1, lim});
      slip(1);
      rd(8'hDF);
      `CHK(rd_val[5], lim == 4'h0)
    end
    for (int i = 0; i < 12; i++) send(i);
    test_done();
  end
  initial begin
    #200000;
    err_total++;
    test_done();
  end
endmodule : tb
